// ==== verilog/alarm_irq_pkg.sv ====
/*
 Constants, types and timing figures shared by the alarm interrupt output block.
 Assumes a 100 MHz system clock and a 32.768 kHz oscillator pin sampled by it.
*/
// Overview of operation
// - Interrupt pins are open-drain, pulled low when asserted
// - Output A takes first alarm or either
// - Output B never driven by first alarm
// - Output B may carry 32 kHz square wave
// - Output asserted while status and enable set
// - Halt flag set after oscillator stopped 25-100 ms
// - Alarm matches on fields, don't-care fields ignored
package alarm_irq_pkg;
    localparam int FIELD_COUNT = 4;
    localparam int FIELD_WIDTH = 8;
    localparam int CLOCK_HZ = 100000000;
    // Qualifying stop time, typical figure, in milliseconds
    localparam int HALT_TIME_MS = 25;
    localparam int HALT_CYCLES = HALT_TIME_MS * (CLOCK_HZ / 1000);
    // One oscillator half period is about 1526 cycles; 4096 cycles with no edge means stopped
    localparam int EDGE_GAP_CYCLES = 4096;
    localparam logic RESET_FLAG = 1'b0;
    // Level put on an open-drain pin while its enable is high
    localparam logic PIN_LOW = 1'b0;
    localparam int COUNT_WIDTH = 24;
    typedef enum logic [0:0] {ROUTE_ALARM0_ONLY, ROUTE_EITHER} route_type;
    typedef enum logic [0:0] {OUT_B_ALARM, OUT_B_SQUARE} out_b_mode_type;
endpackage

// ==== verilog/alarm_match_if.sv ====
/*
 Interface carrying the current time and one alarm setting into a comparator.
 Assumes calendar and alarm registers live on the same clock.
*/
`timescale 1ns/10ps
interface alarm_match_if;
    logic [alarm_irq_pkg::FIELD_WIDTH*alarm_irq_pkg::FIELD_COUNT-1:0] time_now;
    logic [alarm_irq_pkg::FIELD_WIDTH*alarm_irq_pkg::FIELD_COUNT-1:0] alarm_set;
    logic [alarm_irq_pkg::FIELD_COUNT-1:0] dont_care;
    logic hit;
    modport user (output time_now, output alarm_set, output dont_care, input hit);
    modport cmp (input time_now, input alarm_set, input dont_care, output hit);
endinterface

// ==== verilog/alarm_match.sv ====
/*
 Comparator for one time-of-day alarm: seconds, minutes, hours and day fields.
 Assumes inputs are stable registers on the same clock as the caller.
*/
`timescale 1ns/10ps
module alarm_match
(
    alarm_match_if.cmp m
);
    // Compare every field unless marked don't-care
    always_comb
    begin
        m.hit = 1'b1;
        for (int i = 0; i < alarm_irq_pkg::FIELD_COUNT; i++)
        begin
            if (!m.dont_care[i] &&
                m.time_now[i*alarm_irq_pkg::FIELD_WIDTH +: alarm_irq_pkg::FIELD_WIDTH] !=
                m.alarm_set[i*alarm_irq_pkg::FIELD_WIDTH +: alarm_irq_pkg::FIELD_WIDTH])
            begin
                m.hit = 1'b0;
            end
        end
    end
endmodule

// ==== verilog/alarm_interrupt_outputs.sv ====
/*
 Alarm status flags, routing onto two open-drain interrupt pins, 32 kHz output
 and oscillator halt detection.
 Assumes the pins are pulled up outside and OSC_IN is an asynchronous pin.
*/
`timescale 1ns/10ps
module alarm_interrupt_outputs
#(
    parameter int HALT_CYCLES = alarm_irq_pkg::HALT_CYCLES
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic OSC_IN,
    input wire logic TICK,
    input wire logic [31:0] TIME_NOW,
    input wire logic [31:0] ALARM0_SET,
    input wire logic [3:0] ALARM0_DONT_CARE,
    input wire logic [31:0] ALARM1_SET,
    input wire logic [3:0] ALARM1_DONT_CARE,
    input wire logic ALARM0_ENABLE,
    input wire logic ALARM1_ENABLE,
    input wire logic ROUTE_EITHER,
    input wire logic OUT_B_SQUARE,
    input wire logic ALARM0_CLEAR,
    input wire logic ALARM1_CLEAR,
    input wire logic HALT_CLEAR,
    output logic ALARM0_STATUS,
    output logic ALARM1_STATUS,
    output logic OSC_HALT_FLAG,
    output logic ALARM_IRQ_OUT_A_O,
    output logic ALARM_IRQ_OUT_A_OE,
    output logic ALARM_IRQ_OUT_B_O,
    output logic ALARM_IRQ_OUT_B_OE
);
    // Synchronised oscillator and its edges
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_edge;
    // Stop detection counters and their next values
    logic [alarm_irq_pkg::COUNT_WIDTH-1:0] gap_count;
    logic [alarm_irq_pkg::COUNT_WIDTH-1:0] next_gap_count;
    logic [alarm_irq_pkg::COUNT_WIDTH-1:0] halt_count;
    logic [alarm_irq_pkg::COUNT_WIDTH-1:0] next_halt_count;
    logic osc_stopped;
    logic halt_reached;
    // Next values of the sticky flags
    logic next_alarm0_status;
    logic next_alarm1_status;
    logic next_halt_flag;
    // Interrupt causes, routing and pin requests
    logic cause0;
    logic cause1;
    alarm_irq_pkg::route_type route_sel;
    alarm_irq_pkg::out_b_mode_type out_b_mode;
    logic next_irq_a;
    logic next_irq_b;

    // Counter limits cut to the counters' own width
    localparam logic [alarm_irq_pkg::COUNT_WIDTH-1:0] gap_limit =
        alarm_irq_pkg::COUNT_WIDTH'(alarm_irq_pkg::EDGE_GAP_CYCLES);
    localparam logic [alarm_irq_pkg::COUNT_WIDTH-1:0] halt_limit = alarm_irq_pkg::COUNT_WIDTH'(HALT_CYCLES);

    // Sticky flag step: a set in the same cycle as a clear wins
    function automatic logic sticky_next
    (
        input logic current,
        input logic set_now,
        input logic clear_now
    );
        return set_now || (current && !clear_now);
    endfunction

    // Saturating count step, holds once the limit is reached
    function automatic logic [alarm_irq_pkg::COUNT_WIDTH-1:0] count_up
    (
        input logic [alarm_irq_pkg::COUNT_WIDTH-1:0] count,
        input logic [alarm_irq_pkg::COUNT_WIDTH-1:0] limit
    );
        if (count < limit)
        begin
            return count + 1'b1;
        end
        return count;
    endfunction

    // An alarm asks for its pin while status and enable are both set
    function automatic logic irq_cause
    (
        input logic status,
        input logic enable
    );
        return status && enable;
    endfunction

    alarm_match_if m0();
    alarm_match_if m1();

    // Feed the two comparators
    assign m0.time_now = TIME_NOW;
    assign m0.alarm_set = ALARM0_SET;
    assign m0.dont_care = ALARM0_DONT_CARE;
    assign m1.time_now = TIME_NOW;
    assign m1.alarm_set = ALARM1_SET;
    assign m1.dont_care = ALARM1_DONT_CARE;

    // One comparator per alarm
    alarm_match cmp0
    (
        .m(m0)
    );
    alarm_match cmp1
    (
        .m(m1)
    );

    // Alarm status: a match on the tick beats a clear
    assign next_alarm0_status = sticky_next(ALARM0_STATUS, TICK && m0.hit, ALARM0_CLEAR);
    assign next_alarm1_status = sticky_next(ALARM1_STATUS, TICK && m1.hit, ALARM1_CLEAR);

    // Alarm 0 status register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ALARM0_STATUS <= alarm_irq_pkg::RESET_FLAG;
        end
        else
        begin
            ALARM0_STATUS <= next_alarm0_status;
        end
    end

    // Alarm 1 status register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ALARM1_STATUS <= alarm_irq_pkg::RESET_FLAG;
        end
        else
        begin
            ALARM1_STATUS <= next_alarm1_status;
        end
    end

    // Two-stage synchroniser for the oscillator pin, then edge history
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= OSC_IN;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // Any change of the synchronised level is an edge
    assign osc_edge = osc_sync ^ osc_prev;

    // Gap counter: restarts on every edge, a long gap means stopped
    assign next_gap_count = osc_edge ? '0 : count_up(gap_count, gap_limit);
    assign osc_stopped = (gap_count >= gap_limit);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            gap_count <= '0;
        end
        else
        begin
            gap_count <= next_gap_count;
        end
    end

    // Stop time: counts only while the oscillator stays stopped
    assign next_halt_count = osc_stopped ? count_up(halt_count, halt_limit) : '0;
    assign halt_reached = osc_stopped && (halt_count >= halt_limit);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            halt_count <= '0;
        end
        else
        begin
            halt_count <= next_halt_count;
        end
    end

    // Halt flag survives a restart until it is cleared
    assign next_halt_flag = sticky_next(OSC_HALT_FLAG, halt_reached, HALT_CLEAR);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            OSC_HALT_FLAG <= alarm_irq_pkg::RESET_FLAG;
        end
        else
        begin
            OSC_HALT_FLAG <= next_halt_flag;
        end
    end

    // Per-alarm causes and the two routing selections
    assign cause0 = irq_cause(ALARM0_STATUS, ALARM0_ENABLE);
    assign cause1 = irq_cause(ALARM1_STATUS, ALARM1_ENABLE);
    assign route_sel = alarm_irq_pkg::route_type'(ROUTE_EITHER);
    assign out_b_mode = alarm_irq_pkg::out_b_mode_type'(OUT_B_SQUARE);

    // Output A: alarm 0 alone or either alarm
    always_comb
    begin
        case (route_sel)
            alarm_irq_pkg::ROUTE_ALARM0_ONLY:
            begin
                next_irq_a = cause0;
            end
            alarm_irq_pkg::ROUTE_EITHER:
            begin
                next_irq_a = cause0 || cause1;
            end
            default:
            begin
                next_irq_a = cause0;
            end
        endcase
    end

    // Output B: alarm 1 only, or pin low during the oscillator's low phase
    always_comb
    begin
        case (out_b_mode)
            alarm_irq_pkg::OUT_B_ALARM:
            begin
                next_irq_b = cause1;
            end
            alarm_irq_pkg::OUT_B_SQUARE:
            begin
                next_irq_b = !osc_sync;
            end
            default:
            begin
                next_irq_b = cause1;
            end
        endcase
    end

    // Open-drain pins: level always low, enable only while asserted
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ALARM_IRQ_OUT_A_O <= alarm_irq_pkg::PIN_LOW;
            ALARM_IRQ_OUT_A_OE <= alarm_irq_pkg::RESET_FLAG;
            ALARM_IRQ_OUT_B_O <= alarm_irq_pkg::PIN_LOW;
            ALARM_IRQ_OUT_B_OE <= alarm_irq_pkg::RESET_FLAG;
        end
        else
        begin
            ALARM_IRQ_OUT_A_O <= alarm_irq_pkg::PIN_LOW;
            ALARM_IRQ_OUT_A_OE <= next_irq_a;
            ALARM_IRQ_OUT_B_O <= alarm_irq_pkg::PIN_LOW;
            ALARM_IRQ_OUT_B_OE <= next_irq_b;
        end
    end
endmodule

// ==== bench/alarm_irq_sva.sv ====
/*
 Port assertions for the alarm interrupt outputs, bound to the top module.
 Assumes the port names of the top module and a single clock domain.
*/
`timescale 1ns/10ps
module alarm_irq_sva
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic OSC_IN,
    input wire logic TICK,
    input wire logic ALARM0_ENABLE,
    input wire logic ALARM1_ENABLE,
    input wire logic ROUTE_EITHER,
    input wire logic OUT_B_SQUARE,
    input wire logic ALARM0_CLEAR,
    input wire logic HALT_CLEAR,
    input wire logic ALARM0_STATUS,
    input wire logic ALARM1_STATUS,
    input wire logic OSC_HALT_FLAG,
    input wire logic ALARM_IRQ_OUT_A_O,
    input wire logic ALARM_IRQ_OUT_A_OE,
    input wire logic ALARM_IRQ_OUT_B_O,
    input wire logic ALARM_IRQ_OUT_B_OE
);
    logic [12:0] gap;
    logic last;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Cycles since the oscillator pin last moved
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            gap <= 13'h0;
        else if (OSC_IN != last)
            gap <= 13'h0;
        else if (!gap[12])
            gap <= gap + 13'h1;
    // Previous oscillator level
    always_ff @(posedge CLK)
        last <= OSC_IN;
    pins_low_a: assert property (!ALARM_IRQ_OUT_A_O && !ALARM_IRQ_OUT_B_O) else $error("pin high");
    route_a_a: assert property (ALARM_IRQ_OUT_A_OE == $past(ALARM0_STATUS && ALARM0_ENABLE
        || ROUTE_EITHER && ALARM1_STATUS && ALARM1_ENABLE)) else $error("pin A wrong");
    out_b_a: assert property (!$past(OUT_B_SQUARE) |-> ALARM_IRQ_OUT_B_OE ==
        $past(ALARM1_STATUS && ALARM1_ENABLE)) else $error("pin B wrong");
    square_low_a: assert property ($fell(OSC_IN) ##0 OUT_B_SQUARE [*5] |-> ALARM_IRQ_OUT_B_OE)
        else $error("square not low");
    set_cause_a: assert property ($rose(ALARM0_STATUS) |-> $past(TICK)) else $error("status untriggered");
    status_clear_a: assert property ($past(ALARM0_CLEAR) && !$past(TICK) |-> !ALARM0_STATUS)
        else $error("status kept");
    halt_hold_a: assert property (OSC_HALT_FLAG && !HALT_CLEAR |=> OSC_HALT_FLAG) else $error("flag lost");
    halt_wait_a: assert property ($rose(OSC_HALT_FLAG) |-> gap[12]) else $error("flag early");
endmodule
bind alarm_interrupt_outputs alarm_irq_sva chk (.*);

// ==== bench/irq_host.sv ====
/*
 Host interrupt input: pulled-up wire fed by an open-drain pin.
 Assumes the pin is driven only while its enable is high.
*/
`timescale 1ns/10ps
module irq_host
(
    input wire logic oe,
    input wire logic o,
    output logic level
);
    // Pullup wins unless the pin pulls low
    assign level = oe ? o : 1'b1;
endmodule

// ==== bench/testbench.sv ====
/*
 Self-checking bench for the alarm interrupt outputs.
 Assumes the host pin model and the bound assertion checker are compiled with it.
*/
`timescale 1ns/10ps
module testbench;
    logic CLK = 0, RST = 1, OSC_IN = 0, TICK = 0, ALARM0_ENABLE = 0, ALARM1_ENABLE = 0, ROUTE_EITHER = 0;
    logic OUT_B_SQUARE = 0, ALARM0_CLEAR = 0, ALARM1_CLEAR = 0, HALT_CLEAR = 0, run = 1, pa, pb;
    logic [31:0] TIME_NOW = 0, ALARM0_SET = 0, ALARM1_SET = 0;
    logic [3:0] ALARM0_DONT_CARE = 0, ALARM1_DONT_CARE = 0;
    logic ALARM0_STATUS, ALARM1_STATUS, OSC_HALT_FLAG;
    logic ALARM_IRQ_OUT_A_O, ALARM_IRQ_OUT_A_OE, ALARM_IRQ_OUT_B_O, ALARM_IRQ_OUT_B_OE;
    int n_errors = 0, check_count = 0, cyc = 0, ms0 = 0, ms1 = 0, osc_cnt = 0;
    alarm_interrupt_outputs #(.HALT_CYCLES(100)) dut (.*);
    irq_host ha (.oe(ALARM_IRQ_OUT_A_OE), .o(ALARM_IRQ_OUT_A_O), .level(pa));
    irq_host hb (.oe(ALARM_IRQ_OUT_B_OE), .o(ALARM_IRQ_OUT_B_O), .level(pb));
    always #5 CLK = ~CLK;
    // Oscillator pin: half period of 1526 cycles, moved just after an edge
    always @(posedge CLK)
    begin
        osc_cnt++;
        if (run && osc_cnt % 1526 == 0)
            OSC_IN <= #1 ~OSC_IN;
    end
    // Hang guard
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            summarize();
        end
    end
    task summarize();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(string n, logic e, logic g);
        check_count++;
        if (g !== e)
        begin
            $display("BAD %s exp %b got %b", n, e, g);
            n_errors++;
        end
    endtask
    function automatic int hit(logic [31:0] t, logic [31:0] a, logic [3:0] d);
        for (int i = 0; i < 4; i++)
            if (!d[i] && t[8*i+:8] !== a[8*i+:8])
                return 0;
        return 1;
    endfunction
    // One compare strobe with random time, alarms, enables and clears
    task step();
        TIME_NOW = $urandom;
        ALARM0_DONT_CARE = $urandom;
        ALARM1_DONT_CARE = $urandom;
        ALARM0_SET = $urandom % 2 ? TIME_NOW : $urandom;
        ALARM1_SET = $urandom % 2 ? TIME_NOW : $urandom;
        {ALARM0_ENABLE, ALARM1_ENABLE, ROUTE_EITHER} = $urandom;
        ALARM0_CLEAR = $urandom % 3 == 0;
        ALARM1_CLEAR = $urandom % 3 == 0;
        TICK = 1;
        ms0 = hit(TIME_NOW, ALARM0_SET, ALARM0_DONT_CARE) || ms0 && !ALARM0_CLEAR;
        ms1 = hit(TIME_NOW, ALARM1_SET, ALARM1_DONT_CARE) || ms1 && !ALARM1_CLEAR;
        @(posedge CLK); #1;
        {TICK, ALARM0_CLEAR, ALARM1_CLEAR} = 3'h0;
        @(posedge CLK); #1;
        chk("status0", ms0, ALARM0_STATUS);
        chk("status1", ms1, ALARM1_STATUS);
        @(posedge CLK); #1;
        chk("pin_a", !(ms0 && ALARM0_ENABLE || ROUTE_EITHER && ms1 && ALARM1_ENABLE), pa);
        chk("pin_b", !(ms1 && ALARM1_ENABLE), pb);
    endtask
    initial
    begin
        void'($urandom(76));
        repeat (8) @(posedge CLK); #1;
        RST = 0;
        repeat (40) step();
        // Mid-run reset releases both pins and clears every flag
        RST = 1;
        @(posedge CLK); #1;
        chk("rst_flags", 0, ALARM0_STATUS | ALARM1_STATUS | OSC_HALT_FLAG);
        chk("rst_pins", 1, pa & pb);
        RST = 0;
        ms0 = 0;
        ms1 = 0;
        repeat (10) step();
        OUT_B_SQUARE = 1;
        @(negedge OSC_IN); repeat (5) @(posedge CLK); #1;
        chk("sq_low", 0, pb);
        @(posedge OSC_IN); repeat (5) @(posedge CLK); #1;
        chk("sq_high", 1, pb);
        OUT_B_SQUARE = 0;
        chk("no_halt", 0, OSC_HALT_FLAG);
        // Freeze the oscillator right after one of its edges
        @(negedge OSC_IN); @(posedge CLK); #1;
        run = 0;
        repeat (4000) @(posedge CLK); #1;
        chk("halt_early", 0, OSC_HALT_FLAG);
        repeat (300) @(posedge CLK); #1;
        chk("halt", 1, OSC_HALT_FLAG);
        run = 1;
        repeat (4000) @(posedge CLK); #1;
        chk("sticky", 1, OSC_HALT_FLAG);
        HALT_CLEAR = 1;
        @(posedge CLK); #1;
        HALT_CLEAR = 0;
        @(posedge CLK); #1;
        chk("cleared", 0, OSC_HALT_FLAG);
        summarize();
    end
endmodule
